// [dv/ssp_periph.sv]
`timescale 1ns/100ps
module ssp_periph
(
    // serial side
    input  wire ssp_pkg::ssp_pins_t pins,
    output logic                    serial_data_line_i,
    // bench side
    input  wire logic [7:0]         tx_byte,
    output logic [7:0]              rx_byte
);
    logic [2:0] idx_q;
    logic       tx_act;

    initial
    begin
        idx_q = 3'h0;
        tx_act = 1'b0;
        serial_data_line_i = 1'b0;
        rx_byte = 8'h00;
    end

    // next bit while the clock is low, lsb first
    always @(negedge pins.sclk)
    begin
        serial_data_line_i <= tx_byte[idx_q];
        idx_q <= idx_q + 3'h1;
    end

    // enable seen a little late: it drops at the edge of the last bit
    always @(pins.serial_data_line_oe)
        tx_act <= #1 pins.serial_data_line_oe;

    // capture device data; after the last bit the line is inverted 20 ns later
    always @(posedge pins.sclk)
    begin
        if (tx_act)
            rx_byte <= {pins.serial_data_line_o, rx_byte[7:1]};
        if (idx_q == 3'h0)
            serial_data_line_i <= #20 ~serial_data_line_i;
    end
endmodule : ssp_periph

// [dv/ssp_port_assertions.sv]
`timescale 1ns/100ps
module ssp_port_chk
(
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    // register port
    input wire ssp_pkg::ssp_req_t  req,
    input wire logic [15:0]        rdata,
    // serial pins and interrupt
    input wire logic               serial_data_line_i,
    input wire ssp_pkg::ssp_pins_t pins,
    input wire logic               irq
);
    logic [15:0] ctl_q;
    logic [1:0]  msk_q;
    logic [4:0]  lo_q;
    logic [4:0]  hi_q;
    logic [4:0]  half;
    logic        idle;
    logic        tx_wr;
    logic        st_rd;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // shadow copies of control and mask
    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst)
        begin
            ctl_q <= 16'h0000;
            msk_q <= 2'h0;
        end
        else if (req.wr && req.addr == ssp_pkg::OFF_CONTROL)
            ctl_q <= req.wdata;
        else if (req.wr && req.addr == ssp_pkg::OFF_IRQ_MSK)
            msk_q <= req.wdata[1:0];

    // length of the running low and high phases
    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst)
        begin
            lo_q <= 5'h00;
            hi_q <= 5'h00;
        end
        else
        begin
            lo_q <= pins.sclk ? 5'h00 : lo_q + 5'h01;
            hi_q <= !pins.sclk ? 5'h00 : hi_q + {4'h0, hi_q != 5'h1F};
        end

    // idle once high lasts past one half period
    assign half  = 5'h01 << ctl_q[5:4];
    assign idle  = hi_q > half;
    assign tx_wr = req.wr && (req.addr == ssp_pkg::OFF_TX_A
                   || req.addr == ssp_pkg::OFF_TX_B);
    assign st_rd = req.rd && req.addr == ssp_pkg::OFF_STATUS;

    first_en_a: assert property (pins.en_first == ctl_q[0])
        else $error("first enable differs from control");
    second_en_a: assert property (pins.en_second == (ctl_q[1] & ~ctl_q[0]))
        else $error("second enable wrong");
    half_period_a: assert property ($rose(pins.sclk) |-> lo_q == half)
        else $error("serial clock low phase wrong");
    tx_start_a: assert property (tx_wr && idle |=> !pins.sclk && pins.serial_data_line_oe)
        else $error("transmit did not start");
    err_clear_a: assert property (st_rd && ctl_q[1:0] == 2'h0
        && $past(ctl_q[1:0]) == 2'h0 |=> !rdata[2]) else $error("error kept");
    busy_read_a: assert property (st_rd && !pins.sclk |=> rdata[0])
        else $error("busy clear mid transfer");
    status_ro_a: assert property (req.wr && req.addr == ssp_pkg::OFF_STATUS
        && idle |=> $stable(pins)) else $error("status write moved pins");
    rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 16'h0000)
        else $error("read data outside read slot");
    irq_mask_a: assert property (msk_q == 2'h0 && $past(msk_q) == 2'h0 |-> !irq)
        else $error("interrupt while fully masked");

    // main scenarios reached
    cover property ($rose(irq));
    cover property (pins.en_first && ctl_q[1]);
    cover property ($rose(pins.sclk) && ctl_q[5:4] == 2'h3);
endmodule : ssp_port_chk

bind ssp_port ssp_port_chk ssp_port_chk_inst
    (.ref_clk, .sys_rst, .req, .rdata, .serial_data_line_i, .pins, .irq);

// [dv/tb_sync_serial_port.sv]
`timescale 1ns/100ps
module tb_sync_serial_port;
    typedef struct packed {
        logic [1:0] dv;
        logic [1:0] en;
        logic [7:0] tb;
        logic [7:0] pb;
        logic [1:0] eo;
    } ssp_row_t;
    localparam ssp_row_t ROWS [4] = '{'{2'h0, 2'h1, 8'hA5, 8'h5A, 2'h1},
        '{2'h1, 2'h2, 8'h3C, 8'hC3, 2'h2}, '{2'h2, 2'h3, 8'h81, 8'h18, 2'h1},
        '{2'h3, 2'h1, 8'h7E, 8'hE7, 2'h1}};
    logic               ref_clk;
    logic               sys_rst;
    logic               serial_data_line_i;
    logic               irq;
    ssp_pkg::ssp_req_t  req;
    ssp_pkg::ssp_pins_t pins;
    logic [15:0]        rdata;
    logic [15:0]        d;
    logic [7:0]         p_tx;
    logic [7:0]         p_rx;
    int                 miscompares;
    int                 comparisons;

    ssp_port ssp_port_inst (.ref_clk, .sys_rst, .req, .rdata, .serial_data_line_i,
        .pins, .irq);
    ssp_periph ssp_periph_inst (.pins, .serial_data_line_i, .tx_byte(p_tx),
        .rx_byte(p_rx));

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ==========
    // bus tasks
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        req <= '{a, v, 1'b1, 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task wait_irq;
        int n;
        #1 n = 0;
        while (irq !== 1'b1 && n < 300)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        if (irq !== 1'b1)
        begin
            miscompares++;
            wrap_up;
        end
        wr(ssp_pkg::OFF_IRQ_ST, 16'h0003);
    endtask : wait_irq
    task irq_is(input logic v);
        @(posedge ref_clk);
        #1 chk({15'h0000, irq}, {15'h0000, v});
    endtask : irq_is
    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // ==========
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        req = '0;
        p_tx = 8'h00;
        miscompares = 0;
        comparisons = 0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(ssp_pkg::OFF_STATUS);
        chk(d, 16'h0000);
        rd(ssp_pkg::OFF_CONTROL);
        chk(d, 16'h0000);
        chk({14'h0000, pins.en_second, pins.en_first}, 16'h0000);
        $display("reset test done");
        wr(ssp_pkg::OFF_IRQ_MSK, 16'h0001);
        foreach (ROWS[i])
        begin
            p_tx = ROWS[i].pb;
            wr(ssp_pkg::OFF_CONTROL, {10'h000, ROWS[i].dv, 2'h0, ROWS[i].en});
            #1 chk({14'h0000, pins.en_second, pins.en_first}, {14'h0000, ROWS[i].eo});
            wr(i[0] ? ssp_pkg::OFF_TX_B : ssp_pkg::OFF_TX_A, {8'h00, ROWS[i].tb});
            wait_irq;
            rd(ssp_pkg::OFF_STATUS);
            chk(d, 16'h0002);
            chk({8'h00, p_rx}, {8'h00, ROWS[i].tb});
            rd(ssp_pkg::OFF_STATUS);
            chk(d, 16'h0000);
            rd(ssp_pkg::OFF_RX);
            wait_irq;
            rd(ssp_pkg::OFF_RX);
            chk(d, {8'h00, ROWS[i].pb});
            wait_irq;
            $display("row %0d done", i);
        end
        wr(ssp_pkg::OFF_CONTROL, 16'h0031);
        rd(ssp_pkg::OFF_CONTROL);
        chk(d, 16'h0031);
        wr(ssp_pkg::OFF_TX_A, 16'h00C6);
        wr(ssp_pkg::OFF_TX_B, 16'h0099);
        rd(ssp_pkg::OFF_STATUS);
        chk(d, 16'h0005);
        wait_irq;
        chk({8'h00, p_rx}, 16'h00C6);
        wr(ssp_pkg::OFF_CONTROL, 16'h0030);
        rd(ssp_pkg::OFF_STATUS);
        chk(d, 16'h0000);
        $display("collision test done");
        wr(ssp_pkg::OFF_CONTROL, 16'h0001);
        wr(ssp_pkg::OFF_TX_A, 16'h0011);
        wait_irq;
        wr(ssp_pkg::OFF_TX_A, 16'h0022);
        rd(ssp_pkg::OFF_STATUS);
        chk(d, 16'h0001);
        wr(ssp_pkg::OFF_IRQ_MSK, 16'h0000);
        for (int n = 0; n < 300 && d[0] !== 1'b0; n++)
            rd(ssp_pkg::OFF_STATUS);
        chk(d & 16'h0001, 16'h0000);
        irq_is(1'b0);
        wr(ssp_pkg::OFF_IRQ_MSK, 16'h0001);
        irq_is(1'b1);
        wr(ssp_pkg::OFF_IRQ_ST, 16'h0001);
        irq_is(1'b0);
        rd(ssp_pkg::OFF_STATUS);
        wr(ssp_pkg::OFF_STATUS, 16'hFFFF);
        rd(ssp_pkg::OFF_STATUS);
        chk(d, 16'h0000);
        rd(8'h1E);
        chk(d, 16'h0000);
        $display("irq and status test done");
        wrap_up;
    end
endmodule : tb_sync_serial_port

// [verilog/ssp_pkg.sv]
package ssp_pkg;

    // ========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_STATUS  = 8'h10;
    localparam logic [7:0] OFF_CONTROL = 8'h12;
    localparam logic [7:0] OFF_TX_A    = 8'h14;
    localparam logic [7:0] OFF_TX_B    = 8'h16;
    localparam logic [7:0] OFF_RX      = 8'h18;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h1A;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h1C;

    // ========================================================
    // field positions
    localparam int CTL_EN0_BIT   = 0;
    localparam int CTL_EN1_BIT   = 1;
    localparam int CTL_DIV_LSB   = 4;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_DONE_BIT   = 1;
    localparam int ST_ERR_BIT    = 2;
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_ERR_BIT   = 1;

    // ========================================================
    // reset values and counts
    localparam logic [15:0] CONTROL_RST = 16'h0000;
    localparam logic [15:0] STATUS_RST  = 16'h0000;
    localparam logic [1:0]  IRQ_RST     = 2'h0;
    localparam logic [3:0]  BITS_LAST   = 4'h7;

    // ========================================================
    // shift engine states
    typedef enum logic [1:0] {
        SSP_IDLE  = 2'b00,
        SSP_LOW   = 2'b01,
        SSP_HIGH  = 2'b11
    } ssp_state_t;

    // register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ssp_req_t;

    // serial pins
    typedef struct packed {
        logic sclk;
        logic serial_data_line_o;
        logic serial_data_line_oe;
        logic en_first;
        logic en_second;
    } ssp_pins_t;

endpackage : ssp_pkg

// [verilog/ssp_port.sv]
`timescale 1ns/100ps
module ssp_port
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // register port
    input  wire ssp_pkg::ssp_req_t req,
    output logic [15:0]            rdata,
    // serial pins
    input  wire logic              serial_data_line_i,
    output ssp_pkg::ssp_pins_t     pins,
    // interrupt
    output logic                   irq
);

    // ========================================================
    // registers
    logic [15:0]         control_q;
    logic [7:0]          tx_a_q;
    logic [7:0]          tx_b_q;
    logic [7:0]          rx_q;
    logic [7:0]          shift_q;
    logic                busy_q;
    logic                done_q;
    logic                err_q;
    logic [1:0]          irq_st_q;
    logic [1:0]          irq_msk_q;
    logic [15:0]         rdata_q;
    ssp_pkg::ssp_state_t state_q;
    logic [3:0]          div_cnt_q;
    logic [3:0]          bit_cnt_q;
    logic                tx_mode_q;
    logic                sclk_q;
    logic                sdo_q;

    // ========================================================
    // decode
    logic wr_ctl;
    logic wr_tx;
    logic rd_rx;
    logic rd_st;
    logic en_off;
    logic [3:0] half_last;
    logic edge_tick;
    logic done_set;
    logic err_set;
    logic start;

    assign wr_ctl = req.wr && req.addr == ssp_pkg::OFF_CONTROL;
    assign wr_tx  = req.wr && (req.addr == ssp_pkg::OFF_TX_A
                              || req.addr == ssp_pkg::OFF_TX_B);
    assign rd_rx  = req.rd && req.addr == ssp_pkg::OFF_RX;
    assign rd_st  = req.rd && req.addr == ssp_pkg::OFF_STATUS;
    assign en_off = !control_q[ssp_pkg::CTL_EN0_BIT]
                  && !control_q[ssp_pkg::CTL_EN1_BIT];

    // half period in clocks minus one: 0,1,3,7
    always_comb
    begin
        case (control_q[ssp_pkg::CTL_DIV_LSB +: 2])
            2'b00:   half_last = 4'h0;
            2'b01:   half_last = 4'h1;
            2'b10:   half_last = 4'h3;
            default: half_last = 4'h7;
        endcase
    end

    assign edge_tick = div_cnt_q == half_last;
    assign done_set  = state_q == ssp_pkg::SSP_LOW && edge_tick
                     && bit_cnt_q == ssp_pkg::BITS_LAST;
    assign err_set   = (rd_rx || wr_tx) && busy_q;
    // a receive read also starts a receive shift when idle
    assign start     = (wr_tx || rd_rx) && !busy_q;

    // ========================================================
    // control register; status offset is not writable
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            control_q <= ssp_pkg::CONTROL_RST;
        else if (wr_ctl)
            control_q <= {10'h000, req.wdata[5:4], 2'h0,
                          req.wdata[1:0]};
    end

    // transmit data registers
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_a_q <= 8'h00;
            tx_b_q <= 8'h00;
        end
        else if (req.wr && !busy_q)
        begin
            if (req.addr == ssp_pkg::OFF_TX_A)
                tx_a_q <= req.wdata[7:0];
            if (req.addr == ssp_pkg::OFF_TX_B)
                tx_b_q <= req.wdata[7:0];
        end
    end

    // ========================================================
    // shift engine: sclk low half then high half per bit; the last bit goes back to idle after its low half
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q   <= ssp_pkg::SSP_IDLE;
            div_cnt_q <= 4'h0;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            tx_mode_q <= 1'b0;
            busy_q    <= 1'b0;
            sclk_q    <= 1'b1;
            sdo_q     <= 1'b0;
            rx_q      <= 8'h00;
        end
        else
        begin
            case (state_q)
                ssp_pkg::SSP_IDLE:
                begin
                    sclk_q <= 1'b1;
                    if (start)
                    begin
                        state_q   <= ssp_pkg::SSP_LOW;
                        busy_q    <= 1'b1;
                        div_cnt_q <= 4'h0;
                        bit_cnt_q <= 4'h0;
                        tx_mode_q <= wr_tx;
                        shift_q   <= (req.addr == ssp_pkg::OFF_TX_A)
                                   ? req.wdata[7:0] : req.wdata[7:0];
                        sdo_q     <= req.wdata[0];
                        sclk_q    <= 1'b0;
                    end
                end
                ssp_pkg::SSP_LOW:
                begin
                    div_cnt_q <= edge_tick ? 4'h0 : div_cnt_q + 4'h1;
                    if (edge_tick)
                    begin
                        // rising edge: sample input
                        sclk_q  <= 1'b1;
                        shift_q <= {serial_data_line_i, shift_q[7:1]};
                        if (bit_cnt_q == ssp_pkg::BITS_LAST)
                        begin
                            state_q <= ssp_pkg::SSP_IDLE;
                            busy_q  <= 1'b0;
                            if (!tx_mode_q)
                                rx_q <= {serial_data_line_i, shift_q[7:1]};
                        end
                        else
                            state_q <= ssp_pkg::SSP_HIGH;
                    end
                end
                ssp_pkg::SSP_HIGH:
                begin
                    div_cnt_q <= edge_tick ? 4'h0 : div_cnt_q + 4'h1;
                    if (edge_tick)
                    begin
                        sclk_q    <= 1'b0;
                        state_q   <= ssp_pkg::SSP_LOW;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        sdo_q     <= shift_q[0];
                    end
                end
                default:
                    state_q <= ssp_pkg::SSP_IDLE;
            endcase
        end
    end

    // ========================================================
    // status flags; done set wins over clear, but en_off clear wins over err set
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            done_q <= 1'b0;
            err_q  <= 1'b0;
        end
        else
        begin
            if (done_set)
                done_q <= 1'b1;
            else if (rd_rx || wr_tx || rd_st || en_off)
                done_q <= 1'b0;
            if (en_off)
                err_q <= 1'b0;
            else if (err_set)
                err_q <= 1'b1;
        end
    end

    // ========================================================
    // interrupt status and mask
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_st_q  <= ssp_pkg::IRQ_RST;
            irq_msk_q <= ssp_pkg::IRQ_RST;
        end
        else
        begin
            if (req.wr && req.addr == ssp_pkg::OFF_IRQ_MSK)
                irq_msk_q <= req.wdata[1:0];
            if (req.wr && req.addr == ssp_pkg::OFF_IRQ_ST)
                irq_st_q <= (irq_st_q & ~req.wdata[1:0])
                          | {err_set, done_set};
            else
                irq_st_q <= irq_st_q | {err_set, done_set};
        end
    end

    assign irq = |(irq_st_q & irq_msk_q);

    // ========================================================
    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_q <= 16'h0000;
        else if (req.rd)
        begin
            case (req.addr)
                ssp_pkg::OFF_STATUS:
                    rdata_q <= {13'h0000, err_q, done_q, busy_q};
                ssp_pkg::OFF_CONTROL: rdata_q <= control_q;
                ssp_pkg::OFF_TX_A:    rdata_q <= {8'h00, tx_a_q};
                ssp_pkg::OFF_TX_B:    rdata_q <= {8'h00, tx_b_q};
                ssp_pkg::OFF_RX:      rdata_q <= {8'h00, rx_q};
                ssp_pkg::OFF_IRQ_ST:  rdata_q <= {14'h0000, irq_st_q};
                ssp_pkg::OFF_IRQ_MSK: rdata_q <= {14'h0000, irq_msk_q};
                default:              rdata_q <= 16'h0000;
            endcase
        end
        else
            rdata_q <= 16'h0000;
    end

    assign rdata = rdata_q;

    // ========================================================
    // pins
    always_comb
    begin
        pins.sclk      = sclk_q;
        pins.serial_data_line_o   = sdo_q;
        pins.serial_data_line_oe  = tx_mode_q && busy_q;
        pins.en_first  = control_q[ssp_pkg::CTL_EN0_BIT];
        pins.en_second = control_q[ssp_pkg::CTL_EN1_BIT]
                       && !control_q[ssp_pkg::CTL_EN0_BIT];
    end

endmodule : ssp_port
